//--- serial_flash_read_engine.sv
// read-command engine of a serial nor flash behind its spi pins
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_engine (
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   input  wire logic                      spi_clk_in,
   input  wire logic                      chip_select_n_in,
   input  wire logic [3:0]                data_line_in,
   input  wire logic                      busy_in,
   input  wire logic                      quad_enable_bit_in,
   input  wire flash_read_pkg::byte_type  mem_data_in,
   output logic [3:0]                     data_line_out,
   output logic [3:0]                     data_line_oe_n_out,
   output flash_read_pkg::addr_type       mem_addr_out,
   output logic                           execute_in_place_out
);
   import flash_read_pkg::*;

   // ------------------------------------------------------------
   // opcode properties
   // ------------------------------------------------------------
   function automatic lane_type in_lanes_of(input byte_type op);
      case (op)
         OP_DUAL_IO: in_lanes_of = LANE_2;
         OP_QUAD_IO: in_lanes_of = LANE_4;
         default:    in_lanes_of = LANE_1;
      endcase
   endfunction

   function automatic lane_type out_lanes_of(input byte_type op);
      case (op)
         OP_DUAL_OUT, OP_DUAL_IO: out_lanes_of = LANE_2;
         OP_QUAD_OUT, OP_QUAD_IO: out_lanes_of = LANE_4;
         default:                 out_lanes_of = LANE_1;
      endcase
   endfunction

   function automatic count_type dummy_of(input byte_type op);
      case (op)
         OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT: dummy_of = FAST_DUMMY_CLKS;
         OP_QUAD_IO:                        dummy_of = QIO_DUMMY_CLKS;
         default:                           dummy_of = NO_DUMMY;
      endcase
   endfunction

   function automatic logic has_mode(input byte_type op);
      has_mode = (op == OP_DUAL_IO) || (op == OP_QUAD_IO);
   endfunction

   // higher lanes carry the higher bits
   function automatic addr_type shift_in(input addr_type s,
                                         input logic [3:0] d,
                                         input lane_type l);
      case (l)
         LANE_2:  shift_in = {s[ADDR_W-3:0], d[1:0]};
         LANE_4:  shift_in = {s[ADDR_W-5:0], d[3:0]};
         default: shift_in = {s[ADDR_W-2:0], d[0]};
      endcase
   endfunction

   // ------------------------------------------------------------
   // pin stage
   // ------------------------------------------------------------
   pin_sync_if sync ();

   pin_sync u_pin_sync (
      .clk_in           (clk_in),
      .rst_in           (rst_in),
      .spi_clk_in       (spi_clk_in),
      .chip_select_n_in (chip_select_n_in),
      .data_line_in     (data_line_in),
      .sync             (sync.src)
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   state_type  state;
   count_type  cnt;
   addr_type   shift;
   byte_type   opcode;
   logic [2:0] pos;
   addr_type   mem_addr;
   logic [3:0] dout;
   logic [3:0] oe_n;
   byte_type   mode_byte;
   byte_type   cont_opcode;
   logic [2:0] wrap_setting;
   logic       execute_in_place;

   state_type  next_state;
   count_type  next_cnt;
   addr_type   next_shift;
   byte_type   next_opcode;
   logic [2:0] next_pos;
   addr_type   next_mem_addr;
   logic [3:0] next_dout;
   logic [3:0] next_oe_n;
   byte_type   next_mode_byte;
   byte_type   next_cont_opcode;
   logic [2:0] next_wrap_setting;
   logic       next_xip;

   lane_type   lanes;
   lane_type   olanes;
   addr_type   shifted;
   count_type  cnt_sum;
   byte_type   out_bits;
   logic [3:0] pos_sum;
   logic       byte_end;
   logic       wrap_on;
   addr_type   wrap_mask;
   addr_type   addr_inc;
   logic       cont_keep;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_state        = state;
      next_cnt          = cnt;
      next_shift        = shift;
      next_opcode       = opcode;
      next_pos          = pos;
      next_mem_addr     = mem_addr;
      next_dout         = dout;
      next_oe_n         = oe_n;
      next_mode_byte    = mode_byte;
      next_cont_opcode  = cont_opcode;
      next_wrap_setting = wrap_setting;
      lanes = LANE_1;
      if (state == ST_ADDR || state == ST_MODE) begin
         lanes = in_lanes_of(opcode);
      end else if (state == ST_WRAP) begin
         lanes = LANE_4;
      end
      olanes    = out_lanes_of(opcode);
      shifted   = shift_in(shift, sync.data, lanes);
      cnt_sum   = cnt + {3'h0, lanes};
      out_bits  = mem_data_in << pos;
      pos_sum   = {1'b0, pos} + {1'b0, olanes};
      byte_end  = (pos_sum == BYTE_BITS);
      // wrap applies to quad io only
      wrap_on   = (opcode == OP_QUAD_IO) &&
                  !wrap_setting[WRAP_DIS_BIT];
      wrap_mask = (WRAP_MIN_BYTES <<
                   wrap_setting[WRAP_FIELD_HI-WRAP_FIELD_LO:1])
                  - ADDR_STEP;
      addr_inc  = mem_addr + ADDR_STEP;
      cont_keep = (mode_byte[CONT_SEL_HI:CONT_SEL_LO] == CONT_MODE_KEEP);
      case (state)
         ST_IDLE: begin
            if (sync.cs_fall) begin
               next_cnt = COUNT_ZERO;
               if (cont_keep) begin
                  next_state  = ST_ADDR;
                  next_opcode = cont_opcode;
               end else begin
                  next_state = ST_CMD;
               end
            end
         end
         ST_CMD: begin
            if (sync.sclk_rise) begin
               next_shift = shifted;
               next_cnt   = cnt_sum;
               if (cnt_sum == CMD_BITS) begin
                  next_cnt    = COUNT_ZERO;
                  next_opcode = shifted[7:0];
                  next_state  = ST_IGNORE;
                  if (busy_in) begin
                     next_state = ST_IGNORE;
                  end else begin
                     case (shifted[7:0])
                        OP_READ, OP_FAST, OP_DUAL_OUT, OP_DUAL_IO: begin
                           next_state = ST_ADDR;
                        end
                        OP_QUAD_OUT, OP_QUAD_IO: begin
                           if (quad_enable_bit_in) begin
                              next_state = ST_ADDR;
                           end
                        end
                        OP_SET_WRAP: begin
                           next_state = ST_WRAP;
                        end
                        OP_MODE_RESET: begin
                           next_mode_byte = MODE_BYTE_RESET;
                        end
                        default: begin
                           next_state = ST_IGNORE;
                        end
                     endcase
                  end
               end
            end
         end
         ST_ADDR: begin
            if (sync.sclk_rise) begin
               next_shift = shifted;
               next_cnt   = cnt_sum;
               if (cnt_sum == ADDR_BITS) begin
                  next_cnt      = COUNT_ZERO;
                  next_mem_addr = shifted;
                  next_pos      = POS_ZERO;
                  if (has_mode(opcode)) begin
                     next_state = ST_MODE;
                  end else if (dummy_of(opcode) != NO_DUMMY) begin
                     next_state = ST_DUMMY;
                  end else begin
                     next_state = ST_DATA;
                  end
               end
            end
         end
         ST_MODE: begin
            if (sync.sclk_rise) begin
               next_shift = shifted;
               next_cnt   = cnt_sum;
               if (cnt_sum == MODE_BITS) begin
                  next_cnt         = COUNT_ZERO;
                  next_mode_byte   = shifted[7:0];
                  next_cont_opcode = opcode;
                  if (dummy_of(opcode) != NO_DUMMY) begin
                     next_state = ST_DUMMY;
                  end else begin
                     next_state = ST_DATA;
                  end
               end
            end
         end
         ST_DUMMY: begin
            if (sync.sclk_rise) begin
               next_cnt = cnt + COUNT_STEP;
               if (next_cnt == dummy_of(opcode)) begin
                  next_cnt   = COUNT_ZERO;
                  next_state = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            if (sync.sclk_fall) begin
               next_pos = pos_sum[2:0];
               case (olanes)
                  LANE_2: begin
                     next_dout = {2'h0, out_bits[7:6]};
                     next_oe_n = OE_LANE2;
                  end
                  LANE_4: begin
                     next_dout = out_bits[7:4];
                     next_oe_n = OE_DRIVE_ALL;
                  end
                  default: begin
                     next_dout = {2'h0, out_bits[7], 1'b0};
                     next_oe_n = OE_LANE1;
                  end
               endcase
               if (byte_end) begin
                  if (wrap_on) begin
                     next_mem_addr = (mem_addr & ~wrap_mask) |
                                     (addr_inc & wrap_mask);
                  end else begin
                     next_mem_addr = addr_inc;
                  end
               end
            end
         end
         ST_WRAP: begin
            if (sync.sclk_rise) begin
               next_shift = shifted;
               next_cnt   = cnt_sum;
               if (cnt_sum == WRAP_TOTAL_BITS) begin
                  next_cnt          = COUNT_ZERO;
                  next_wrap_setting =
                     shifted[WRAP_FIELD_HI:WRAP_FIELD_LO];
                  next_state        = ST_IGNORE;
               end
            end
         end
         ST_IGNORE: begin
            next_state = ST_IGNORE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (sync.cs_rise) begin
         next_state = ST_IDLE;
         next_oe_n  = OE_RELEASE;
         next_cnt   = COUNT_ZERO;
         next_pos   = POS_ZERO;
      end
      next_xip = (next_mode_byte[CONT_SEL_HI:CONT_SEL_LO] == CONT_MODE_KEEP);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state        <= ST_IDLE;
         cnt          <= COUNT_ZERO;
         shift        <= ADDR_RESET;
         opcode       <= MODE_BYTE_RESET;
         pos          <= POS_ZERO;
         mem_addr     <= ADDR_RESET;
         dout         <= DOUT_RESET;
         oe_n         <= OE_RELEASE;
         mode_byte    <= MODE_BYTE_RESET;
         cont_opcode  <= MODE_BYTE_RESET;
         wrap_setting <= WRAP_SETTING_RESET;
         execute_in_place          <= 1'b0;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         shift        <= next_shift;
         opcode       <= next_opcode;
         pos          <= next_pos;
         mem_addr     <= next_mem_addr;
         dout         <= next_dout;
         oe_n         <= next_oe_n;
         mode_byte    <= next_mode_byte;
         cont_opcode  <= next_cont_opcode;
         wrap_setting <= next_wrap_setting;
         execute_in_place          <= next_xip;
      end
   end

   assign data_line_out        = dout;
   assign data_line_oe_n_out   = oe_n;
   assign mem_addr_out         = mem_addr;
   assign execute_in_place_out = execute_in_place;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   a_cs_release: assert property (
      sync.cs_rise |=> (data_line_oe_n_out == OE_RELEASE) &&
                       (state == ST_IDLE))
      else $error("lines not released after select rise");
   a_busy_ignore: assert property (
      (state == ST_CMD && sync.sclk_rise && cnt_sum == CMD_BITS &&
       busy_in && !sync.cs_rise) |=> state == ST_IGNORE)
      else $error("command taken while busy");
   a_quad_refuse: assert property (
      (state == ST_CMD && sync.sclk_rise && cnt_sum == CMD_BITS &&
       !quad_enable_bit_in && !sync.cs_rise &&
       (shifted[7:0] == OP_QUAD_OUT || shifted[7:0] == OP_QUAD_IO))
      |=> state == ST_IGNORE)
      else $error("quad read taken without quad enable");
   a_dummy_quiet: assert property (
      state == ST_DUMMY |-> data_line_oe_n_out == OE_RELEASE)
      else $error("driving during dummy clocks");
   a_single_lane: assert property (
      (state == ST_DATA && out_lanes_of(opcode) == LANE_1) |->
      (data_line_oe_n_out == OE_RELEASE ||
       data_line_oe_n_out == OE_LANE1))
      else $error("single read drives a wrong line");
   a_quad_drive: assert property (
      (state == ST_DATA && out_lanes_of(opcode) == LANE_4 &&
       sync.sclk_fall && !sync.cs_rise) |=>
      data_line_oe_n_out == OE_DRIVE_ALL)
      else $error("quad read not on four lines");
   a_addr_step: assert property (
      (state == ST_DATA && sync.sclk_fall && byte_end && !wrap_on &&
       !sync.cs_rise) |=> mem_addr_out == $past(mem_addr_out) + ADDR_STEP)
      else $error("address did not step by one");
   a_wrap_window: assert property (
      (state == ST_DATA && wrap_on && sync.sclk_fall && !sync.cs_rise)
      |=> (mem_addr_out & ~wrap_mask) ==
          ($past(mem_addr_out) & ~wrap_mask))
      else $error("wrap left its section");
   a_cont_skip: assert property (
      (state == ST_IDLE && sync.cs_fall && cont_keep) |=>
      state == ST_ADDR && opcode == cont_opcode)
      else $error("continuous mode did not skip opcode");
   a_cont_full: assert property (
      (state == ST_IDLE && sync.cs_fall && !cont_keep) |=>
      state == ST_CMD)
      else $error("opcode phase skipped without mode");
   a_wrap_default: assert property (
      $past(rst_in) |-> wrap_setting[WRAP_DIS_BIT])
      else $error("wrap not disabled after reset");
   a_mode_clear: assert property (
      (state == ST_CMD && sync.sclk_rise && cnt_sum == CMD_BITS &&
       !busy_in && !sync.cs_rise && shifted[7:0] == OP_MODE_RESET)
      |=> mode_byte == MODE_BYTE_RESET)
      else $error("mode byte not cleared by reset command");

   c_quad_data: cover property (
      state == ST_DATA && out_lanes_of(opcode) == LANE_4 && byte_end);
   c_cont_entry: cover property (
      state == ST_IDLE && sync.cs_fall && cont_keep);
   c_wrap_turn: cover property (
      state == ST_DATA && wrap_on && byte_end && sync.sclk_fall);
endmodule // serial_flash_read_engine
`default_nettype wire

//--- flash_read_pkg.sv
// constants, types and states of the serial flash read engine
// What this block does
// - opcode then 24-bit address, sampled rising
// - data out msb first on falling edge
// - address steps by one after each byte
// - chip select high ends transfer, releases lines
// - standard read ignored while busy
// - fast read adds eight dummy clocks
// - dual output read drives two lines
// - quad output needs quad enable, four lines
// - dual io takes address on two lines
// - mode byte follows address, low nibble ignored
// - mode select 10 skips next opcode
// - other mode select needs opcode again
// - mode reset command clears stored mode byte
// - quad io: four-line address, four dummy clocks
// - quad io needs quad enable
// - last wrap setting applies to quad io
// - wrap stays inside aligned section of page
// - three wrap bits: disable plus length
// - wrap command: opcode, 24 dummy, wrap byte
// - wrap length 8, 16, 32, 64 bytes
// - wrap disable resets to one
package flash_read_pkg;
   localparam int ADDR_W = 24;
   typedef logic [ADDR_W-1:0] addr_type;
   typedef logic [7:0]        byte_type;
   typedef logic [2:0]        lane_type;
   typedef logic [5:0]        count_type;
   // ------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------
   localparam byte_type OP_READ       = 8'h03;
   localparam byte_type OP_FAST       = 8'h0b;
   localparam byte_type OP_DUAL_OUT   = 8'h3b;
   localparam byte_type OP_QUAD_OUT   = 8'h6b;
   localparam byte_type OP_DUAL_IO    = 8'hbb;
   localparam byte_type OP_QUAD_IO    = 8'heb;
   localparam byte_type OP_SET_WRAP   = 8'h77;
   localparam byte_type OP_MODE_RESET = 8'hff;
   // ------------------------------------------------------------
   // phase lengths
   // ------------------------------------------------------------
   localparam count_type CMD_BITS        = 6'h08;
   localparam count_type ADDR_BITS       = 6'h18;
   localparam count_type MODE_BITS       = 6'h08;
   localparam count_type WRAP_TOTAL_BITS = 6'h20;
   localparam count_type FAST_DUMMY_CLKS = 6'h08;
   localparam count_type QIO_DUMMY_CLKS  = 6'h04;
   localparam count_type NO_DUMMY        = 6'h00;
   localparam count_type COUNT_ZERO      = 6'h00;
   localparam count_type COUNT_STEP      = 6'h01;
   localparam logic [3:0] BYTE_BITS      = 4'h8;
   localparam logic [2:0] POS_ZERO       = 3'h0;
   localparam lane_type LANE_1 = 3'h1;
   localparam lane_type LANE_2 = 3'h2;
   localparam lane_type LANE_4 = 3'h4;
   // ------------------------------------------------------------
   // mode and wrap fields
   // ------------------------------------------------------------
   localparam int CONT_SEL_HI = 5;
   localparam int CONT_SEL_LO = 4;
   localparam logic [1:0] CONT_MODE_KEEP = 2'h2;
   localparam byte_type   MODE_BYTE_RESET = 8'h00;
   localparam int WRAP_FIELD_HI = 6;
   localparam int WRAP_FIELD_LO = 4;
   localparam int WRAP_DIS_BIT  = 0;
   localparam logic [2:0] WRAP_SETTING_RESET = 3'h1;
   localparam addr_type WRAP_MIN_BYTES = 24'h000008;
   localparam addr_type ADDR_STEP      = 24'h000001;
   localparam addr_type ADDR_RESET     = 24'h000000;
   // ------------------------------------------------------------
   // output enables, low drives
   // ------------------------------------------------------------
   localparam logic [3:0] OE_RELEASE   = 4'hf;
   localparam logic [3:0] OE_LANE1     = 4'hd;
   localparam logic [3:0] OE_LANE2     = 4'hc;
   localparam logic [3:0] OE_DRIVE_ALL = 4'h0;
   localparam logic [3:0] DOUT_RESET   = 4'h0;
   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_CMD    = 8'h02,
      ST_ADDR   = 8'h04,
      ST_MODE   = 8'h08,
      ST_DUMMY  = 8'h10,
      ST_DATA   = 8'h20,
      ST_WRAP   = 8'h40,
      ST_IGNORE = 8'h80
   } state_type;
endpackage

//--- pin_sync_if.sv
// synchronised pin levels and edges between the pin stage and engine
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_fall;
   logic       cs_rise;
   logic [3:0] data;
   modport src (output sclk_rise, sclk_fall, cs_fall, cs_rise, data);
   modport dst (input  sclk_rise, sclk_fall, cs_fall, cs_rise, data);
endinterface
`default_nettype wire

//--- pin_sync.sv
// two-flop synchronisers and edge detection for the spi pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       spi_clk_in,
   input  wire logic       chip_select_n_in,
   input  wire logic [3:0] data_line_in,
   pin_sync_if.src         sync
);
   // serial clock and select idle high, so no false edge after reset
   localparam logic [5:0] STAGE_RESET = 6'h03;
   localparam logic [1:0] PREV_RESET  = 2'h3;
   logic [5:0] stage1;
   logic [5:0] stage2;
   logic [1:0] prev;
   logic [5:0] next_stage1;
   logic [5:0] next_stage2;
   logic [1:0] next_prev;

   always_comb begin
      next_stage1 = {data_line_in, chip_select_n_in, spi_clk_in};
      next_stage2 = stage1;
      next_prev   = stage2[1:0];
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stage1 <= STAGE_RESET;
         stage2 <= STAGE_RESET;
         prev   <= PREV_RESET;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
         prev   <= next_prev;
      end
   end

   // edges from second stage against third
   assign sync.sclk_rise = stage2[0] & ~prev[0];
   assign sync.sclk_fall = ~stage2[0] & prev[0];
   assign sync.cs_fall   = ~stage2[1] & prev[1];
   assign sync.cs_rise   = stage2[1] & ~prev[1];
   assign sync.data      = stage2[5:2];
endmodule // pin_sync
`default_nettype wire

//--- spi_host.sv
// spi host model that frames reads towards the flash pins
`timescale 1ns/1ps
`default_nettype none
module spi_host (
   input  wire logic       clk_in,
   input  wire logic [3:0] line_in,
   output logic            spi_clk_out,
   output logic            cs_n_out,
   output logic [3:0]      data_out,
   output logic [3:0]      drive_out
);
   // serial clock idles high and stands still outside frames
   initial begin
      spi_clk_out = 1'b1;
      cs_n_out = 1'b1;
      data_out = 4'h0;
      drive_out = 4'h0;
   end
   task automatic tick(input logic [3:0] d, en, output logic [3:0] s);
      spi_clk_out = 1'b0;
      data_out = d;
      drive_out = en;
      repeat (4) @(negedge clk_in);
      spi_clk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      s = line_in;
   endtask
   task automatic send(input logic [31:0] v, input int n, l, input logic e);
      logic [31:0] sh;
      logic [3:0]  s;
      sh = v << (32 - n);
      for (int i = 0; i < n; i += l) begin
         tick(sh[31:28] >> (4 - l), e ? 4'((1 << l) - 1) : 4'h0, s);
         sh = sh << l;
      end
   endtask
   task automatic recv(input int l, output logic [7:0] b);
      logic [3:0] s;
      b = 8'h00;
      for (int i = 0; i < 8; i += l) begin
         tick(4'h0, 4'h0, s);
         b = (b << l) | 8'(l == 1 ? {3'h0, s[1]} : s & 4'((1 << l) - 1));
      end
   endtask
   task automatic frame(input logic open);
      cs_n_out = !open;
      drive_out = 4'h0;
      repeat (8) @(negedge clk_in);
   endtask
endmodule // spi_host
`default_nettype wire

//--- serial_flash_read_engine_tb_top.sv
// self-checking bench of the serial flash read engine
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_engine_tb_top;
   import flash_read_pkg::*;
   localparam addr_type NO_WRAP = 24'hffffff;
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       busy;
   logic       qe;
   byte_type   mem_byte;
   logic       flt = 1'b0;
   logic       ok = 1'b1;
   logic       spi_clk, cs_n, execute_in_place;
   logic [3:0] hd, hen, dout, oe_n, lines;
   addr_type   maddr;
   addr_type   wm = NO_WRAP;
   int         fails = 0;
   int         tests_run = 0;
   always #4 clk_in = ~clk_in;
   // undriven lines keep changing so no stale level reads as data
   always @(posedge clk_in) flt <= ~flt;
   always_comb
      for (int k = 0; k < 4; k++)
         lines[k] = !oe_n[k] ? dout[k] : hen[k] ? hd[k] : flt ^ k[0];
   function automatic byte_type mem_val(input addr_type a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   always_comb mem_byte = mem_val(maddr);
   spi_host spi_host_i (.clk_in(clk_in), .line_in(lines),
      .spi_clk_out(spi_clk), .cs_n_out(cs_n), .data_out(hd), .drive_out(hen));
   serial_flash_read_engine serial_flash_read_engine_i (.clk_in(clk_in),
      .rst_in(rst_in), .spi_clk_in(spi_clk), .chip_select_n_in(cs_n),
      .data_line_in(lines), .busy_in(busy), .quad_enable_bit_in(qe),
      .mem_data_in(mem_byte), .data_line_out(dout),
      .data_line_oe_n_out(oe_n), .mem_addr_out(maddr),
      .execute_in_place_out(execute_in_place));
   task automatic check(input string what, input logic [23:0] e, g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task automatic xfer(input byte_type op, input logic skip,
                       input addr_type a, input byte_type md, input int n);
      int       al, dum, dl;
      byte_type b;
      al = op == OP_DUAL_IO ? 2 : op == OP_QUAD_IO ? 4 : 1;
      dl = op inside {OP_DUAL_OUT, OP_DUAL_IO} ? 2 : op == OP_READ ? 1 :
           op == OP_FAST ? 1 : 4;
      dum = op == OP_QUAD_IO ? 4 : op inside {OP_READ, OP_DUAL_IO} ? 0 : 8;
      spi_host_i.frame(1'b1);
      if (!skip) spi_host_i.send(32'(op), 8, 1, 1'b1);
      spi_host_i.send(32'(a), 24, al, 1'b1);
      if (al > 1) spi_host_i.send(32'(md), 8, al, 1'b1);
      if (dum > 0) spi_host_i.send(32'h0, dum, 1, 1'b0);
      for (int i = 0; i < n; i++) begin
         spi_host_i.recv(dl, b);
         if (ok) check("data", 24'(mem_val((a & ~wm) | ((a + 24'(i)) & wm))),
                       24'(b));
      end
      check("enables", ok ? 24'(dl == 1 ? 4'hd : dl == 2 ? 4'hc : 4'h0) :
            24'hf, 24'(oe_n));
      spi_host_i.frame(1'b0);
      check("release", 24'hf, 24'(oe_n));
   endtask
   task automatic set_wrap(input byte_type w);
      spi_host_i.frame(1'b1);
      spi_host_i.send(32'(OP_SET_WRAP), 8, 1, 1'b1);
      spi_host_i.send({24'h0, w}, 32, 4, 1'b1);
      spi_host_i.frame(1'b0);
   endtask
   task automatic t_basic();
      check("reset", 24'hf, 24'(oe_n));
      xfer(OP_READ, 1'b0, 24'hfffffe, 8'h00, 3);
      xfer(OP_FAST, 1'b0, 24'h000123, 8'h00, 2);
      xfer(OP_DUAL_OUT, 1'b0, 24'h012345, 8'h00, 3);
      xfer(OP_QUAD_OUT, 1'b0, 24'h0abcde, 8'h00, 3);
      xfer(OP_DUAL_IO, 1'b0, 24'h3456f8, 8'h0f, 3);
      xfer(OP_QUAD_IO, 1'b0, 24'h7654f6, 8'h0d, 4);
      $display("basic reads done");
   endtask
   task automatic t_refuse();
      busy = 1'b1;
      ok = 1'b0;
      xfer(OP_READ, 1'b0, 24'h000010, 8'h00, 2);
      busy = 1'b0;
      qe = 1'b0;
      xfer(OP_QUAD_OUT, 1'b0, 24'h000010, 8'h00, 2);
      xfer(OP_QUAD_IO, 1'b0, 24'h000010, 8'h00, 2);
      qe = 1'b1;
      ok = 1'b1;
      xfer(OP_READ, 1'b0, 24'h000010, 8'h00, 2);
      $display("refusals done");
   endtask
   task automatic t_cont();
      xfer(OP_QUAD_IO, 1'b0, 24'h100200, 8'h2f, 2);
      check("xip", 24'h1, 24'(execute_in_place));
      xfer(OP_QUAD_IO, 1'b1, 24'h100300, 8'h20, 2);
      spi_host_i.frame(1'b1);
      spi_host_i.send(32'hffffffff, 32, 4, 1'b1);
      spi_host_i.frame(1'b0);
      check("xip", 24'h0, 24'(execute_in_place));
      spi_host_i.frame(1'b1);
      spi_host_i.send(32'(OP_MODE_RESET), 8, 1, 1'b1);
      spi_host_i.frame(1'b0);
      check("release", 24'hf, 24'(oe_n));
      xfer(OP_QUAD_IO, 1'b0, 24'h100400, 8'h00, 2);
      xfer(OP_DUAL_IO, 1'b0, 24'h200000, 8'ha5, 2);
      xfer(OP_DUAL_IO, 1'b1, 24'h200100, 8'hc0, 2);
      check("xip", 24'h0, 24'(execute_in_place));
      xfer(OP_DUAL_IO, 1'b0, 24'h200200, 8'h00, 2);
      $display("continuous mode done");
   endtask
   task automatic t_wrap();
      for (int w = 0; w < 4; w++) begin
         set_wrap(8'(w << 5));
         wm = 24'((8 << w) - 1);
         xfer(OP_QUAD_IO, 1'b0, 24'h0a00f5, 8'h00, (8 << w) + 2);
      end
      set_wrap(8'h70);
      wm = NO_WRAP;
      xfer(OP_QUAD_IO, 1'b0, 24'h0a00f5, 8'h00, 12);
      // wrap left on across a reset must come back disabled
      set_wrap(8'h00);
      rst_in = 1'b1;
      repeat (8) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      xfer(OP_QUAD_IO, 1'b0, 24'h0a00f5, 8'h00, 12);
      $display("wrap done");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      busy = 1'b0;
      qe = 1'b1;
      repeat (8) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      t_basic();
      t_refuse();
      t_cont();
      t_wrap();
      results();
   end
   initial begin
      #400000;
      fails++;
      results();
   end
endmodule // serial_flash_read_engine_tb_top
`default_nettype wire
